// *** bim_pkg.sv ***
// package for the built-in io signal multiplexer: map, codes, reset values, carriers
`default_nettype none
package bim_pkg;

   // ***********************************************
   // register byte offsets
   // ***********************************************
   localparam logic [4:0] IN_FUNC_LO_OFS = 5'h00;
   localparam logic [4:0] IN_FUNC_HI_OFS = 5'h04;
   localparam logic [4:0] OUT_FUNC_OFS = 5'h08;
   localparam logic [4:0] OUT_IMAGE_OFS = 5'h0c;
   localparam logic [4:0] IN_IMAGE_OFS = 5'h10;
   localparam logic [4:0] PIN_STATE_OFS = 5'h14;
   localparam logic [4:0] SCAN_END_OFS = 5'h18;
   localparam logic [4:0] CFG_ERR_OFS = 5'h1c;

   // ***********************************************
   // field positions
   // ***********************************************
   localparam int SCAN_END_BIT = 0;
   localparam int CFG_ERR_BIT = 0;
   localparam int PIN_STATE_OUT_LSB = 16;
   localparam int FUNC_W = 4;

   // ***********************************************
   // function codes
   // ***********************************************
   localparam logic [3:0] IN_GP = 4'h0;
   localparam logic [3:0] IN_INT = 4'h1;
   localparam logic [3:0] IN_PCATCH = 4'h2;
   localparam logic [3:0] IN_CNT = 4'h3;
   localparam logic [3:0] IN_POS = 4'h4;
   localparam logic [3:0] OUT_GP = 4'h0;
   localparam logic [3:0] OUT_CNT = 4'h1;
   localparam logic [3:0] OUT_POS = 4'h2;

   // ***********************************************
   // values after reset
   // ***********************************************
   localparam logic [31:0] IN_FUNC_RST = 32'h0000_0000;
   localparam logic [31:0] OUT_FUNC_RST = 32'h0000_0000;
   localparam logic [7:0] OUT_IMAGE_RST = 8'h00;
   localparam logic [15:0] IN_IMAGE_RST = 16'h0000;

   // ***********************************************
   // carriers to and from the function engines
   // ***********************************************
   typedef struct packed {
      logic phase_a;
      logic phase_b;
      logic phase_z;
      logic func_in;
      logic latch_in;
   } bim_cnt_in_t;

   typedef struct packed {
      logic zero_sig;
      logic ext_cmd;
      logic drive_ready;
      logic near_dog;
      logic upper_limit;
      logic lower_limit;
   } bim_pos_in_t;

   typedef struct packed {
      logic coin1;
      logic coin2;
   } bim_cnt_out_t;

   typedef struct packed {
      logic dev_clear;
      logic cw_pulse_a;
      logic ccw_sign_b;
   } bim_pos_out_t;

endpackage : bim_pkg
`default_nettype wire

// *** bim_io_mux.sv ***
// built-in io signal multiplexer with its ahb-lite register slave
//
// What this block does
// RULE1: counter ch1 enabled routes A=in0, B=in1, Z=in4, function=in6, latch=in8.
// RULE2: counter ch2 enabled routes A=in2, B=in3, Z=in5, function=in7, latch=in9.
// RULE3: coincidence 1 of ch1/ch2 on out0/out1, coincidence 2 on out2/out3.
// RULE4: axis1 takes zero in4, command in6, ready in8, dog inA, limits inC/inE.
// RULE5: axis2 takes zero in5, command in7, ready in9, dog inB, limits inD/inF.
// RULE6: axis deviation clear on out2/3, cw on out4/5, ccw on out6/7.
// RULE7: with ch1 in use, in0 and in1 cannot become interrupt inputs.
// RULE8: with ch2 in use, in2 and in3 cannot become interrupt inputs.
// RULE9: an optional engine input not selected frees its pin for other use.
// RULE10: pins without a role in counter or positioning stay usable otherwise.
// RULE11: engine output takes its pin only when configured, else general output.
// RULE12: unused coincidence 2 leaves out2/out3 as general outputs.
// RULE13: input image copies every physical input except pulse-catch pins.
// RULE14: pulse-catch pin sets its image bit for one scan after rising edge.
// RULE15: inputs unused by the selected engine act as general inputs.
// RULE16: input leds show physical inputs, unaffected by image writes.
// RULE17: each output pin driven by its selected source.
// RULE18: engine-owned output pins ignore the program output image.
// RULE19: output image never takes engine output states.
// RULE20: output leds show the actual pin state.
// RULE21: one static function per pin, exactly one function at a time.
// RULE22: input image refreshed at each end of scan.
`default_nettype none
module bim_io_mux (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // external pins
   input wire logic [15:0] ext_in,
   output logic [7:0] ext_out,
   // indicators
   output logic [15:0] input_indicator_leds,
   output logic [7:0] output_indicator_leds,
   // toward the function engines
   output bim_pkg::bim_cnt_in_t [1:0] cnt_in,
   output bim_pkg::bim_pos_in_t [1:0] pos_in,
   output logic [15:0] irq_in,
   // from the function engines
   input wire bim_pkg::bim_cnt_out_t [1:0] cnt_out,
   input wire bim_pkg::bim_pos_out_t [1:0] pos_out
);

   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] prev;
      logic [15:0] pend;
      logic [15:0] in_image;
      logic [15:0][3:0] in_func;
      logic [7:0][3:0] out_func;
      logic [7:0] out_image;
      logic [7:0] ext_out;
      logic [15:0] in_leds;
      logic [7:0] out_leds;
      logic [15:0] irq_in;
      bim_pkg::bim_cnt_in_t [1:0] cnt_in;
      bim_pkg::bim_pos_in_t [1:0] pos_in;
      logic cfg_err;
      logic wr_pend;
      logic [4:0] wr_ofs;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } bim_state_t;

   bim_state_t r;
   bim_state_t n;

   // ***********************************************
   // decoding helpers
   // ***********************************************
   // counter channels in use, judged by their phase-a pins
   function automatic logic [1:0] cnt_use(input logic [15:0][3:0] f);
      cnt_use = {f[2] == bim_pkg::IN_CNT, f[0] == bim_pkg::IN_CNT};
   endfunction : cnt_use

   // whether code is allowed on input pin p under the whole configuration f
   function automatic logic in_ok(input int p, input logic [15:0][3:0] f);
      logic [1:0] use_c;
      logic ok;
      use_c = cnt_use(f);
      ok = 1'b0;
      unique case (f[p])
         bim_pkg::IN_GP, bim_pkg::IN_PCATCH: ok = 1'b1;
         bim_pkg::IN_INT: ok = !((p < 2 && use_c[0]) || (p >= 2 && p < 4 && use_c[1])); // RULE7 RULE8
         bim_pkg::IN_CNT: ok = (p < 10); // RULE10
         bim_pkg::IN_POS: ok = (p >= 4); // RULE10
         default: ok = 1'b0;
      endcase
      in_ok = ok;
   endfunction : in_ok

   // whether code is allowed on output pin p
   function automatic logic out_ok(input int p, input logic [3:0] code);
      logic ok;
      ok = 1'b0;
      unique case (code)
         bim_pkg::OUT_GP: ok = 1'b1;
         bim_pkg::OUT_CNT: ok = (p < 4);
         bim_pkg::OUT_POS: ok = (p >= 2);
         default: ok = 1'b0;
      endcase
      out_ok = ok;
   endfunction : out_ok

   // whole-config legality check of a candidate input function set
   function automatic logic in_cfg_ok(input logic [15:0][3:0] f);
      logic ok;
      ok = 1'b1;
      for (int p = 0; p < 16; p++) begin
         ok = ok & in_ok(p, f);
      end
      in_cfg_ok = ok;
   endfunction : in_cfg_ok

   // ***********************************************
   // routing of pins to engines
   // ***********************************************
   logic [15:0] pin;
   logic [15:0] is_cnt;
   logic [15:0] is_pos;
   logic [15:0] is_int;
   logic [15:0] is_pc;
   logic [7:0] gp_sel;
   logic [7:0] cnt_drv;
   logic [7:0] pos_drv;
   logic [7:0] pin_out;

   assign pin = r.sync2;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_in
         assign is_cnt[gi] = (r.in_func[gi] == bim_pkg::IN_CNT);
         assign is_pos[gi] = (r.in_func[gi] == bim_pkg::IN_POS);
         assign is_int[gi] = (r.in_func[gi] == bim_pkg::IN_INT);
         assign is_pc[gi] = (r.in_func[gi] == bim_pkg::IN_PCATCH);
      end
      for (gi = 0; gi < 8; gi++) begin : g_out
         assign gp_sel[gi] = (r.out_func[gi] == bim_pkg::OUT_GP);
         assign pin_out[gi] = (r.out_func[gi] == bim_pkg::OUT_CNT) ? cnt_drv[gi] :
                              (r.out_func[gi] == bim_pkg::OUT_POS) ? pos_drv[gi] :
                              r.out_image[gi]; // RULE17 RULE18 RULE11
      end
   endgenerate

   // engine output candidates per pin
   assign cnt_drv = {4'h0, cnt_out[1].coin2, cnt_out[0].coin2,
                     cnt_out[1].coin1, cnt_out[0].coin1}; // RULE3 RULE12
   assign pos_drv = {pos_out[1].ccw_sign_b, pos_out[0].ccw_sign_b,
                     pos_out[1].cw_pulse_a, pos_out[0].cw_pulse_a,
                     pos_out[1].dev_clear, pos_out[0].dev_clear, 2'h0}; // RULE6

   // ***********************************************
   // bus decode
   // ***********************************************
   logic addr_phase;
   logic mapped_in;
   logic [4:0] ofs_in;
   logic wr_now;
   logic scan_end;
   logic [15:0] rise;
   logic [15:0][3:0] cand;
   logic [7:0][3:0] ocand;
   logic ocand_ok;
   logic err_set;
   logic err_clr;

   assign addr_phase = hsel && htrans[1] && hready;
   assign mapped_in = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0);
   assign ofs_in = haddr[4:0];
   assign wr_now = r.wr_pend && hready;
   assign scan_end = wr_now && (r.wr_ofs == bim_pkg::SCAN_END_OFS)
                     && hwdata[bim_pkg::SCAN_END_BIT];
   assign rise = r.sync2 & ~r.prev;

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      n = r;
      cand = r.in_func;
      ocand = r.out_func;
      ocand_ok = 1'b1;
      err_set = 1'b0;
      err_clr = 1'b0;

      // two-stage synchroniser, then the edge history
      n.sync1 = ext_in;
      n.sync2 = r.sync1;
      n.prev = r.sync2;

      // pulse catch collects edges between scan ends
      n.pend = (r.pend | rise) & is_pc; // RULE14

      // register writes in the data phase; illegal configurations are refused whole
      if (wr_now) begin
         unique case (r.wr_ofs)
            bim_pkg::IN_FUNC_LO_OFS, bim_pkg::IN_FUNC_HI_OFS: begin
               if (r.wr_ofs == bim_pkg::IN_FUNC_LO_OFS) begin
                  cand[7:0] = hwdata;
               end else begin
                  cand[15:8] = hwdata;
               end
               if (in_cfg_ok(cand)) begin
                  n.in_func = cand; // RULE21 RULE9
               end else begin
                  err_set = 1'b1; // RULE7 RULE8
               end
            end
            bim_pkg::OUT_FUNC_OFS: begin
               ocand = hwdata;
               for (int p = 0; p < 8; p++) begin
                  ocand_ok = ocand_ok & out_ok(p, ocand[p]);
               end
               if (ocand_ok) begin
                  n.out_func = ocand; // RULE21 RULE11
               end else begin
                  err_set = 1'b1;
               end
            end
            bim_pkg::OUT_IMAGE_OFS: n.out_image = hwdata[7:0];
            bim_pkg::IN_IMAGE_OFS: n.in_image = hwdata[15:0];
            bim_pkg::CFG_ERR_OFS: err_clr = hwdata[bim_pkg::CFG_ERR_BIT];
            default: ;
         endcase
      end
      n.cfg_err = (r.cfg_err & ~err_clr) | err_set;

      // end of scan refreshes the input image
      if (scan_end) begin
         for (int p = 0; p < 16; p++) begin
            if (is_pc[p]) begin
               n.in_image[p] = r.pend[p] | rise[p]; // RULE14
            end else begin
               n.in_image[p] = pin[p]; // RULE13 RULE15 RULE22
            end
         end
         n.pend = 16'h0000;
      end

      // engine inputs, each gated by its own pin selection
      n.cnt_in[0].phase_a = pin[0] & is_cnt[0]; // RULE1
      n.cnt_in[0].phase_b = pin[1] & is_cnt[1]; // RULE1
      n.cnt_in[0].phase_z = pin[4] & is_cnt[4]; // RULE1 RULE9
      n.cnt_in[0].func_in = pin[6] & is_cnt[6]; // RULE1 RULE9
      n.cnt_in[0].latch_in = pin[8] & is_cnt[8]; // RULE1 RULE9
      n.cnt_in[1].phase_a = pin[2] & is_cnt[2]; // RULE2
      n.cnt_in[1].phase_b = pin[3] & is_cnt[3]; // RULE2
      n.cnt_in[1].phase_z = pin[5] & is_cnt[5]; // RULE2 RULE9
      n.cnt_in[1].func_in = pin[7] & is_cnt[7]; // RULE2 RULE9
      n.cnt_in[1].latch_in = pin[9] & is_cnt[9]; // RULE2 RULE9
      for (int a = 0; a < 2; a++) begin
         n.pos_in[a].zero_sig = pin[4 + a] & is_pos[4 + a]; // RULE4 RULE5
         n.pos_in[a].ext_cmd = pin[6 + a] & is_pos[6 + a]; // RULE4 RULE5
         n.pos_in[a].drive_ready = pin[8 + a] & is_pos[8 + a]; // RULE4 RULE5
         n.pos_in[a].near_dog = pin[10 + a] & is_pos[10 + a]; // RULE4 RULE5
         n.pos_in[a].upper_limit = pin[12 + a] & is_pos[12 + a]; // RULE4 RULE5
         n.pos_in[a].lower_limit = pin[14 + a] & is_pos[14 + a]; // RULE4 RULE5
      end
      n.irq_in = pin & is_int;

      // output pins and indicators; the output image is never written back
      n.ext_out = pin_out; // RULE17 RULE19
      n.out_leds = pin_out; // RULE20
      n.in_leds = pin; // RULE16

      // address phase: zero wait state, read data taken from the updated state, pin state read from the current state
      n.hreadyout = 1'b1;
      n.hresp = 1'b0;
      if (hready) begin
         n.wr_pend = addr_phase && hwrite && mapped_in;
         n.wr_ofs = ofs_in;
         n.hrdata = 32'h0000_0000;
         if (addr_phase && !hwrite && mapped_in) begin
            unique case (ofs_in)
               bim_pkg::IN_FUNC_LO_OFS: n.hrdata = n.in_func[7:0];
               bim_pkg::IN_FUNC_HI_OFS: n.hrdata = n.in_func[15:8];
               bim_pkg::OUT_FUNC_OFS: n.hrdata = n.out_func;
               bim_pkg::OUT_IMAGE_OFS: n.hrdata = {24'h0, n.out_image};
               bim_pkg::IN_IMAGE_OFS: n.hrdata = {16'h0, n.in_image};
               bim_pkg::PIN_STATE_OFS: n.hrdata = {8'h0, r.ext_out, pin};
               bim_pkg::CFG_ERR_OFS: n.hrdata = {31'h0, n.cfg_err};
               default: n.hrdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.in_func <= {2{bim_pkg::IN_FUNC_RST}};
         r.out_func <= bim_pkg::OUT_FUNC_RST;
         r.out_image <= bim_pkg::OUT_IMAGE_RST;
         r.in_image <= bim_pkg::IN_IMAGE_RST;
         r.hreadyout <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   assign hrdata = r.hrdata;
   assign hreadyout = r.hreadyout;
   assign hresp = r.hresp;
   assign ext_out = r.ext_out;
   assign input_indicator_leds = r.in_leds;
   assign output_indicator_leds = r.out_leds;
   assign cnt_in = r.cnt_in;
   assign pos_in = r.pos_in;
   assign irq_in = r.irq_in;

   // hsize is accepted but only whole-word transfers are used
   logic unused_ok;
   assign unused_ok = ^hsize;

endmodule : bim_io_mux
`default_nettype wire

// *** bim_io_mux_monitor.sv ***
// checker for pin routing and indicator relations of the io multiplexer
`default_nettype none
module bim_io_mux_monitor (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pins and indicators
   input wire logic [15:0] ext_in,
   input wire logic [7:0] ext_out,
   input wire logic [15:0] input_indicator_leds,
   input wire logic [7:0] output_indicator_leds,
   // toward the engines
   input wire bim_pkg::bim_cnt_in_t [1:0] cnt_in,
   input wire bim_pkg::bim_pos_in_t [1:0] pos_in,
   input wire logic [15:0] irq_in
);
   // ****
   // pin history three edges deep, valid once age reaches three
   // ****
   logic [1:0] age;
   logic [15:0] h1, h2, h3;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         age <= 2'h0;
         h1 <= 16'h0;
         h2 <= 16'h0;
         h3 <= 16'h0;
      end else begin
         age <= (age == 2'h3) ? age : age + 2'h1;
         h1 <= ext_in;
         h2 <= h1;
         h3 <= h2;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   in_leds_a: assert property (age == 2'h3 |-> input_indicator_leds == h3)
      else $error("input leds differ from pins");
   ch1_route_a: assert property (age == 2'h3 |->
      (cnt_in[0] & ~{h3[0], h3[1], h3[4], h3[6], h3[8]}) == 5'h0)
      else $error("counter one input without its pin");
   ch2_route_a: assert property (age == 2'h3 |->
      (cnt_in[1] & ~{h3[2], h3[3], h3[5], h3[7], h3[9]}) == 5'h0)
      else $error("counter two input without its pin");
   ax1_route_a: assert property (age == 2'h3 |->
      (pos_in[0] & ~{h3[4], h3[6], h3[8], h3[10], h3[12], h3[14]}) == 6'h0)
      else $error("axis one input without its pin");
   ax2_route_a: assert property (age == 2'h3 |->
      (pos_in[1] & ~{h3[5], h3[7], h3[9], h3[11], h3[13], h3[15]}) == 6'h0)
      else $error("axis two input without its pin");
   ch1_no_irq_a: assert property (!(cnt_in[0].phase_a && irq_in[1:0] != 2'h0))
      else $error("interrupt beside counter one");
   ch2_no_irq_a: assert property (!(cnt_in[1].phase_a && irq_in[3:2] != 2'h0))
      else $error("interrupt beside counter two");
   out_leds_a: assert property (output_indicator_leds == ext_out)
      else $error("output leds differ from pins");
   one_func_a: assert property ($onehot0({irq_in[4], cnt_in[0].phase_z,
      pos_in[0].zero_sig}))
      else $error("pin four routed twice");
endmodule : bim_io_mux_monitor
bind bim_io_mux bim_io_mux_monitor bim_io_mux_monitor_i (.hclk(hclk), .hresetn(hresetn),
   .ext_in(ext_in), .ext_out(ext_out), .input_indicator_leds(input_indicator_leds),
   .output_indicator_leds(output_indicator_leds), .cnt_in(cnt_in), .pos_in(pos_in),
   .irq_in(irq_in));
`default_nettype wire

// *** bim_field_model.sv ***
// far-side model: switches and sensors on the sixteen input pins
`default_nettype none
module bim_field_model (
   // clock
   input wire logic hclk,
   // contact levels and the pins they reach
   input wire logic [15:0] level,
   output var logic [15:0] ext_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // contacts settle one clock after they are moved
   initial ext_in = 16'h0;
   always @(posedge hclk) begin
      ext_in <= level;
   end
endmodule : bim_field_model
`default_nettype wire

// *** bim_io_mux_tb.sv ***
// self-checking bench for the io multiplexer
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module bim_io_mux_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [31:0] lo, hi, of;
      logic [15:0] pins;
      logic [9:0] cnt;
      logic [11:0] pos;
      logic [7:0] out;
   } bim_row_t;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp;
   logic [15:0] level = 16'h0, ext_in, input_indicator_leds, irq_in;
   logic [7:0] ext_out, output_indicator_leds;
   bim_pkg::bim_cnt_in_t [1:0] cnt_in;
   bim_pkg::bim_pos_in_t [1:0] pos_in;
   bim_pkg::bim_cnt_out_t [1:0] cnt_out = 4'h6;
   bim_pkg::bim_pos_out_t [1:0] pos_out = 6'h1d;
   int err_count = 0, checks = 0;
   bim_row_t rows [5] = '{
      '{32'h0, 32'h0, 32'h0, 16'hffff, 10'h0, 12'h0, 8'h3c},
      '{32'h3333_3333, 32'h33, 32'h1111, 16'h0155, 10'h217, 12'h0, 8'h39},
      '{32'h4444_0000, 32'h4444_4444, 32'h2222_2200, 16'h5550, 10'h0, 12'h03f, 8'he4},
      '{32'h33, 32'h0, 32'h1, 16'hffff, 10'h018, 12'h0, 8'h3d},
      '{32'h4444_0000, 32'h4444_4444, 32'h0, 16'haaa0, 10'h0, 12'hfc0, 8'h3c}};
   always #5 hclk = ~hclk;
   bim_io_mux bim_io_mux_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_in(ext_in),
      .ext_out(ext_out), .input_indicator_leds(input_indicator_leds),
      .output_indicator_leds(output_indicator_leds), .cnt_in(cnt_in), .pos_in(pos_in),
      .irq_in(irq_in), .cnt_out(cnt_out), .pos_out(pos_out));
   bim_field_model bim_field_model_i (.hclk(hclk), .level(level), .ext_in(ext_in));
   // ****
   // ahb-lite single word transfer
   // ****
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [4:0] o, input logic [31:0] d);
      bus(1'b1, {27'h0, o}, d);
   endtask : wr
   task automatic rdw(input logic [4:0] o);
      bus(1'b0, {27'h0, o}, 32'h0);
   endtask : rdw
   task automatic conclude();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   initial begin
      #100us;
      err_count++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4) begin
         bus(1'b0, 32'(a), 32'h0);
         `CHK(rd, 32'h0)
      end
      wr(bim_pkg::OUT_IMAGE_OFS, 32'h3c);
      for (int i = 0; i < 5; i++) begin
         level <= rows[i].pins;
         wr(bim_pkg::IN_FUNC_LO_OFS, rows[i].lo);
         wr(bim_pkg::IN_FUNC_HI_OFS, rows[i].hi);
         wr(bim_pkg::OUT_FUNC_OFS, rows[i].of);
         wr(bim_pkg::SCAN_END_OFS, 32'h1);
         repeat (3) @(posedge hclk);
         `CHK(cnt_in, rows[i].cnt)
         `CHK(pos_in, rows[i].pos)
         `CHK(ext_out, rows[i].out)
         `CHK(output_indicator_leds, rows[i].out)
         `CHK(input_indicator_leds, rows[i].pins)
         rdw(bim_pkg::IN_IMAGE_OFS);
         `CHK(rd, {16'h0, rows[i].pins})
      end
      rdw(bim_pkg::OUT_IMAGE_OFS);
      `CHK(rd, 32'h3c)
      wr(bim_pkg::OUT_FUNC_OFS, 32'h0001_0000);
      rdw(bim_pkg::OUT_FUNC_OFS);
      `CHK(rd, 32'h0)
      `CHK(ext_out, 8'h3c)
      level <= 16'h8001;
      wr(bim_pkg::IN_FUNC_LO_OFS, 32'h0);
      wr(bim_pkg::IN_FUNC_LO_OFS, 32'h13);
      rdw(bim_pkg::CFG_ERR_OFS);
      `CHK(rd[0], 1'b1)
      rdw(bim_pkg::IN_FUNC_LO_OFS);
      `CHK(rd, 32'h0)
      wr(bim_pkg::CFG_ERR_OFS, 32'h1);
      wr(bim_pkg::IN_FUNC_LO_OFS, 32'h1300);
      rdw(bim_pkg::IN_FUNC_LO_OFS);
      `CHK(rd, 32'h0)
      wr(bim_pkg::IN_FUNC_LO_OFS, 32'h133);
      rdw(bim_pkg::IN_FUNC_LO_OFS);
      `CHK(rd, 32'h133)
      wr(bim_pkg::IN_FUNC_LO_OFS, 32'h1);
      repeat (3) @(posedge hclk);
      `CHK(irq_in, 16'h0001)
      wr(bim_pkg::IN_IMAGE_OFS, 32'h1234);
      rdw(bim_pkg::IN_IMAGE_OFS);
      `CHK(rd, 32'h1234)
      `CHK(input_indicator_leds, 16'h8001)
      level <= 16'h0;
      wr(bim_pkg::IN_FUNC_LO_OFS, 32'h0020_0000);
      wr(bim_pkg::SCAN_END_OFS, 32'h1);
      level <= 16'h0020;
      @(posedge hclk);
      level <= 16'h0;
      repeat (6) @(posedge hclk);
      wr(bim_pkg::SCAN_END_OFS, 32'h1);
      rdw(bim_pkg::IN_IMAGE_OFS);
      `CHK(rd, 32'h20)
      wr(bim_pkg::SCAN_END_OFS, 32'h1);
      rdw(bim_pkg::IN_IMAGE_OFS);
      `CHK(rd, 32'h0)
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdw(bim_pkg::IN_FUNC_LO_OFS);
      `CHK(rd, 32'h0)
      `CHK({hresp, ext_out, output_indicator_leds}, 17'h0)
      conclude();
   end
endmodule : bim_io_mux_tb
`default_nettype wire
